// ===== hdl/meie_pkg.sv
// Constants for the metering event interrupt enable block.
// Assumes a 32-bit AHB-Lite bus, word registers at index * 4.
package meie_pkg;
   // ---------------------------------------------
   // Register indices (byte address = index * 4)
   // ---------------------------------------------
   localparam logic [15:0] MASK_IDX = 16'hE50A;
   localparam logic [15:0] STAT_IDX = 16'hE502;
   localparam logic [15:0] ACCM_IDX = 16'hE701;
   localparam logic [15:0] CFM_IDX  = 16'hE610;
   localparam logic [15:0] HCFG_IDX = 16'hE900;
   localparam logic [15:0] LCYC_IDX = 16'hE60C;
   // ---------------------------------------------
   // Field layout
   // ---------------------------------------------
   localparam logic [31:0] EN_WMASK = 32'h000F_FFFB;
   localparam int EVW       = 20;
   localparam int B_TA      = 0;
   localparam int B_FA      = 1;
   localparam int B_FR      = 3;
   localparam int B_VA      = 4;
   localparam int B_LINE    = 5;
   localparam int B_APS     = 6;
   localparam int B_PS1     = 9;
   localparam int B_FRS     = 10;
   localparam int B_PS2     = 13;
   localparam int B_PIN     = 14;
   localparam int B_DSP     = 17;
   localparam int B_PS3     = 18;
   localparam int B_HARM    = 19;
   localparam int ACCM_W    = 8;
   localparam int B_SIGN_SEL = 6;
   localparam int CFM_W     = 12;
   localparam int SEL_W     = 3;
   localparam int SEL1_LSB  = 0;
   localparam int SEL2_LSB  = 3;
   localparam int SEL3_LSB  = 6;
   localparam int DIS_LSB   = 9;
   localparam int HCFG_W    = 8;
   localparam int B_HIMM    = 0;
   localparam int HST_LSB   = 3;
   localparam int HST_W     = 2;
   localparam int HARMONIC_UPDATE_RATE_LSB = 5;
   localparam int HARMONIC_UPDATE_RATE_W   = 3;
   localparam int LCNT_W    = 16;
   localparam int LMODE     = 16;
   localparam int LCYC_W    = 17;
   // ---------------------------------------------
   // Harmonic start-up states
   // ---------------------------------------------
   typedef enum logic [1:0] {
      H_IDLE   = 2'h0,
      H_SETTLE = 2'h1,
      H_RUN    = 2'h3
   } meie_hstate_t;
endpackage

// ===== hdl/meie_top.sv
// Interrupt enable mask, event flags and interrupt pin, group 0.
// Assumes event inputs synchronous to clk; AHB-Lite single slave.
`timescale 1ns/10ps
module meie_top #(
   parameter int SETTLE_UNIT_CYC = 40000,
   parameter int HCW             = 18
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Energy accumulator bit 30, phases A..C
   input  wire logic [2:0]  total_active_b30,
   input  wire logic [2:0]  fund_active_b30,
   input  wire logic [2:0]  fund_reactive_b30,
   input  wire logic [2:0]  apparent_b30,
   // Power signs, phases A..C or paths 1..3
   input  wire logic [2:0]  active_sign_total,
   input  wire logic [2:0]  active_sign_fund,
   input  wire logic [2:0]  fund_var_sign,
   input  wire logic [2:0]  pulse_path_sum_sign,
   // Pulse generators, active low
   input  wire logic [2:0]  pulse_raw_n,
   // Event strobes
   input  wire logic        half_cycle_tick,
   input  wire logic        dsp_cycle_done,
   input  wire logic        harmonic_setup,
   input  wire logic        harmonic_update,
   // Pins and configuration outputs
   output logic             energy_pulse_out_1,
   output logic             energy_pulse_out_2,
   output logic             energy_pulse_out_3,
   output logic             interrupt_out_1_n,
   output logic [2:0]       pulse_out1_power_select,
   output logic [2:0]       pulse_out2_power_select,
   output logic [2:0]       pulse_out3_power_select,
   output logic [2:0]       harmonic_update_rate
);
   typedef struct packed {
      logic [31:0]                      mask;
      logic [31:0]                      stat;
      logic [meie_pkg::ACCM_W-1:0]      accm;
      logic [meie_pkg::CFM_W-1:0]       cfm;
      logic [meie_pkg::HCFG_W-1:0]      hcfg;
      logic [meie_pkg::LCYC_W-1:0]      lcyc;
      logic                             wr_pend;
      logic                             rd_pend;
      logic [15:0]                      idx;
      logic [31:0]                      rdata;
      logic                             irq_n;
      logic                             prim;
      logic [2:0]                       e_ta;
      logic [2:0]                       e_fa;
      logic [2:0]                       e_fr;
      logic [2:0]                       e_va;
      logic [2:0]                       s_ap;
      logic [2:0]                       s_fr;
      logic [2:0]                       s_ps;
      logic [2:0]                       pin_n;
      logic [2:0]                       out_n;
      logic [meie_pkg::LCNT_W-1:0]      lc_cnt;
      logic [HCW-1:0]                   hc_cnt;
      meie_pkg::meie_hstate_t           hst;
   } meie_state_t;

   meie_state_t s_ff;
   meie_state_t nxt_s;
   logic [meie_pkg::EVW-1:0] ev;
   logic [2:0]               ap_sign;
   logic [31:0]              clr;
   logic                     take;
   logic [HCW-1:0]           settle;
   logic [15:0]              lc_lim;

   // ---------------------------------------------
   // Bus, pin and configuration outputs
   // ---------------------------------------------
   assign hreadyout = ~s_ff.rd_pend;
   assign hrdata    = s_ff.rdata;
   assign hresp     = 1'b0;
   assign take      = hsel & htrans[1] & hready;

   assign interrupt_out_1_n  = s_ff.irq_n;
   assign energy_pulse_out_1 = s_ff.out_n[0];
   assign energy_pulse_out_2 = s_ff.out_n[1];
   assign energy_pulse_out_3 = s_ff.out_n[2];
   assign pulse_out1_power_select =
      s_ff.cfm[meie_pkg::SEL1_LSB +: meie_pkg::SEL_W];
   assign pulse_out2_power_select =
      s_ff.cfm[meie_pkg::SEL2_LSB +: meie_pkg::SEL_W];
   assign pulse_out3_power_select =
      s_ff.cfm[meie_pkg::SEL3_LSB +: meie_pkg::SEL_W];
   assign harmonic_update_rate =
      s_ff.hcfg[meie_pkg::HARMONIC_UPDATE_RATE_LSB +: meie_pkg::HARMONIC_UPDATE_RATE_W];

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      ev    = '0;
      clr   = '0;
      ap_sign = s_ff.accm[meie_pkg::B_SIGN_SEL] ?
                active_sign_fund : active_sign_total;
      settle = HCW'(SETTLE_UNIT_CYC) *
         (HCW'(s_ff.hcfg[meie_pkg::HST_LSB +: meie_pkg::HST_W])
          + HCW'(1));
      lc_lim = s_ff.lcyc[meie_pkg::LCNT_W-1:0];
      nxt_s.prim = 1'b1;
      if (s_ff.prim) begin
         ev[meie_pkg::B_TA] = |(total_active_b30 ^ s_ff.e_ta);
         ev[meie_pkg::B_FA] = |(fund_active_b30 ^ s_ff.e_fa);
         ev[meie_pkg::B_FR] = |(fund_reactive_b30 ^ s_ff.e_fr);
         ev[meie_pkg::B_VA] = |(apparent_b30 ^ s_ff.e_va);
         ev[meie_pkg::B_APS +: 3] = ap_sign ^ s_ff.s_ap;
         ev[meie_pkg::B_PS1] =
            pulse_path_sum_sign[0] ^ s_ff.s_ps[0];
         ev[meie_pkg::B_FRS +: 3] = fund_var_sign ^ s_ff.s_fr;
         ev[meie_pkg::B_PS2] =
            pulse_path_sum_sign[1] ^ s_ff.s_ps[1];
         ev[meie_pkg::B_PIN +: 3] = s_ff.pin_n & ~pulse_raw_n;
         ev[meie_pkg::B_DSP] = dsp_cycle_done;
         ev[meie_pkg::B_PS3] =
            pulse_path_sum_sign[2] ^ s_ff.s_ps[2];
         ev[meie_pkg::B_HARM] =
            harmonic_update & (s_ff.hst == meie_pkg::H_RUN);
      end
      nxt_s.e_ta  = total_active_b30;
      nxt_s.e_fa  = fund_active_b30;
      nxt_s.e_fr  = fund_reactive_b30;
      nxt_s.e_va  = apparent_b30;
      nxt_s.s_ap  = ap_sign;
      nxt_s.s_fr  = fund_var_sign;
      nxt_s.s_ps  = pulse_path_sum_sign;
      nxt_s.pin_n = pulse_raw_n;
      // Disabled pulse pins rest high
      nxt_s.out_n = pulse_raw_n |
         s_ff.cfm[meie_pkg::DIS_LSB +: 3];

      if (!s_ff.lcyc[meie_pkg::LMODE]) begin
         nxt_s.lc_cnt = '0;
      end else if (half_cycle_tick) begin
         if (s_ff.lc_cnt + 16'h0001 >= lc_lim &&
             lc_lim != 16'h0000) begin
            ev[meie_pkg::B_LINE] = s_ff.prim;
            nxt_s.lc_cnt = '0;
         end else begin
            nxt_s.lc_cnt = s_ff.lc_cnt + 16'h0001;
         end
      end

      // Harmonic start-up sequencing
      unique case (s_ff.hst)
         meie_pkg::H_IDLE: begin
            nxt_s.hc_cnt = '0;
         end
         meie_pkg::H_SETTLE: begin
            if (s_ff.hc_cnt <= HCW'(1)) begin
               nxt_s.hst = meie_pkg::H_RUN;
            end else begin
               nxt_s.hc_cnt = s_ff.hc_cnt - HCW'(1);
            end
         end
         meie_pkg::H_RUN: begin
            nxt_s.hc_cnt = '0;
         end
         default: begin
            nxt_s.hst = meie_pkg::H_IDLE;
         end
      endcase
      if (harmonic_setup) begin
         if (s_ff.hcfg[meie_pkg::B_HIMM]) begin
            nxt_s.hst = meie_pkg::H_RUN;
         end else begin
            nxt_s.hst    = meie_pkg::H_SETTLE;
            nxt_s.hc_cnt = settle;
         end
      end

      // Bus data phase
      nxt_s.wr_pend = 1'b0;
      nxt_s.rd_pend = 1'b0;
      if (s_ff.wr_pend) begin
         unique case (s_ff.idx)
            meie_pkg::MASK_IDX: begin
               nxt_s.mask = hwdata & meie_pkg::EN_WMASK;
            end
            meie_pkg::STAT_IDX: begin
               clr = hwdata;
            end
            meie_pkg::ACCM_IDX: begin
               nxt_s.accm = hwdata[meie_pkg::ACCM_W-1:0];
            end
            meie_pkg::CFM_IDX: begin
               nxt_s.cfm = hwdata[meie_pkg::CFM_W-1:0];
            end
            meie_pkg::HCFG_IDX: begin
               nxt_s.hcfg = hwdata[meie_pkg::HCFG_W-1:0];
            end
            meie_pkg::LCYC_IDX: begin
               nxt_s.lcyc = hwdata[meie_pkg::LCYC_W-1:0];
            end
            default: begin
               clr = '0;
            end
         endcase
      end
      if (s_ff.rd_pend) begin
         unique case (s_ff.idx)
            meie_pkg::MASK_IDX: nxt_s.rdata = s_ff.mask;
            meie_pkg::STAT_IDX: nxt_s.rdata = s_ff.stat;
            meie_pkg::ACCM_IDX: nxt_s.rdata = 32'(s_ff.accm);
            meie_pkg::CFM_IDX:  nxt_s.rdata = 32'(s_ff.cfm);
            meie_pkg::HCFG_IDX: nxt_s.rdata = 32'(s_ff.hcfg);
            meie_pkg::LCYC_IDX: nxt_s.rdata = 32'(s_ff.lcyc);
            default:            nxt_s.rdata = 32'h0000_0000;
         endcase
      end
      // Bus address phase
      if (take) begin
         nxt_s.idx     = (haddr[31:18] == 14'h0000 &&
                          haddr[1:0] == 2'h0) ?
                         haddr[17:2] : 16'h0000;
         nxt_s.wr_pend = hwrite;
         nxt_s.rd_pend = ~hwrite;
      end
      // Set wins over write-one-to-clear
      nxt_s.stat = (s_ff.stat & ~clr) | 32'(ev);
      nxt_s.irq_n = ~|(s_ff.stat & s_ff.mask);
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_ff       <= '0;
         s_ff.irq_n <= 1'b1;
         s_ff.out_n <= 3'h7;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_irq_from_flag: assert property (
      |(s_ff.stat & s_ff.mask) |=> !interrupt_out_1_n)
      else $error("flag and enable did not raise irq");
   a_pin_low_cause: assert property (
      !interrupt_out_1_n |-> $past(|(s_ff.stat & s_ff.mask)))
      else $error("irq pin low without cause");
   a_bit2_no_effect: assert property (
      s_ff.mask[2] == 1'b0 && s_ff.stat[2] == 1'b0)
      else $error("reserved enable bit 2 active");
   a_upper_mask_zero: assert property (
      s_ff.mask[31:20] == 12'h000)
      else $error("reserved upper enable bits set");
   a_energy_half_set: assert property (
      s_ff.prim && |(total_active_b30 ^ s_ff.e_ta)
      |=> s_ff.stat[0])
      else $error("energy bit 30 change lost");
   a_pulse_fall_set: assert property (
      s_ff.prim && s_ff.pin_n[0] && !pulse_raw_n[0]
      |=> s_ff.stat[meie_pkg::B_PIN] &&
          $past(s_ff.stat[meie_pkg::B_PIN]) == 1'b0 ||
          s_ff.stat[meie_pkg::B_PIN])
      else $error("pulse edge flag lost");
   a_dsp_done_set: assert property (
      s_ff.prim && dsp_cycle_done
      |=> s_ff.stat[meie_pkg::B_DSP])
      else $error("dsp done flag lost");
   a_settle_blocks: assert property (
      s_ff.hst == meie_pkg::H_SETTLE &&
      !s_ff.stat[meie_pkg::B_HARM]
      |=> !s_ff.stat[meie_pkg::B_HARM])
      else $error("harmonic flag during settling");
   a_immediate_run: assert property (
      harmonic_setup && s_ff.hcfg[meie_pkg::B_HIMM]
      |=> s_ff.hst == meie_pkg::H_RUN)
      else $error("immediate harmonic start missed");
   a_reset_clears: assert property (
      disable iff (1'b0)
      !nrst |=> s_ff.mask == 32'h0000_0000 &&
                interrupt_out_1_n)
      else $error("enables not cleared by reset");
   a_line_needs_mode: assert property (
      !s_ff.lcyc[meie_pkg::LMODE] &&
      !s_ff.stat[meie_pkg::B_LINE]
      |=> !s_ff.stat[meie_pkg::B_LINE])
      else $error("line event outside line mode");
   a_fund_half_set: assert property (
      s_ff.prim && |(fund_active_b30 ^ s_ff.e_fa)
      |=> s_ff.stat[meie_pkg::B_FA])
      else $error("fundamental energy bit 30 change lost");
   a_var_half_set: assert property (
      s_ff.prim && |(fund_reactive_b30 ^ s_ff.e_fr)
      |=> s_ff.stat[meie_pkg::B_FR])
      else $error("reactive energy bit 30 change lost");
   a_va_half_set: assert property (
      s_ff.prim && |(apparent_b30 ^ s_ff.e_va)
      |=> s_ff.stat[meie_pkg::B_VA])
      else $error("apparent energy bit 30 change lost");
   a_var_sign_set: assert property (
      s_ff.prim && fund_var_sign[0] != s_ff.s_fr[0]
      |=> s_ff.stat[meie_pkg::B_FRS])
      else $error("phase A reactive sign flag lost");
   a_path1_sign_set: assert property (
      s_ff.prim && pulse_path_sum_sign[0] != s_ff.s_ps[0]
      |=> s_ff.stat[meie_pkg::B_PS1])
      else $error("path 1 sum sign flag lost");
   a_path2_sign_set: assert property (
      s_ff.prim && pulse_path_sum_sign[1] != s_ff.s_ps[1]
      |=> s_ff.stat[meie_pkg::B_PS2])
      else $error("path 2 sum sign flag lost");
   a_path3_sign_set: assert property (
      s_ff.prim && pulse_path_sum_sign[2] != s_ff.s_ps[2]
      |=> s_ff.stat[meie_pkg::B_PS3])
      else $error("path 3 sum sign flag lost");
   a_harm_run_set: assert property (
      s_ff.prim && harmonic_update && s_ff.hst == meie_pkg::H_RUN
      |=> s_ff.stat[meie_pkg::B_HARM])
      else $error("harmonic refresh flag lost");
endmodule

// ===== tb/meie_host_irq.sv
// Host side of the interrupt line: counts requests, one per falling edge of irq_n.
// Assumes an active-low level interrupt synchronous to clk.
`timescale 1ns/10ps
module meie_host_irq (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Interrupt line and count
   input  wire logic        irq_n,
   output logic [15:0]      irq_count
);
   logic prev_ff;
   always_ff @(posedge clk) begin
      prev_ff <= irq_n;
      if (!nrst) begin
         irq_count <= 16'h0000;
      end else if (prev_ff && !irq_n) begin
         irq_count <= irq_count + 16'h0001;
      end
   end
endmodule

// ===== tb/meie_top_tb_top.sv
// Self-checking bench for the group 0 interrupt enable block.
// Assumes one AHB-Lite slave, short harmonic settle unit.
`timescale 1ns/10ps
module meie_top_tb_top;
   logic        clk, nrst, hwrite, irq;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic        hreadyout, hresp;
   logic [2:0]  tb30, fb30, rb30, ab30, sgt, sgf, vs, ps, raw_n;
   logic [2:0]  pout, s1, s2, s3, rate;
   logic [3:0]  stb;
   logic [15:0] irq_count;
   int          errors, tests_run, nirq, cyc;

   meie_top #(.SETTLE_UNIT_CYC(4), .HCW(18)) dut_u (
      .clk(clk), .nrst(nrst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .total_active_b30(tb30), .fund_active_b30(fb30),
      .fund_reactive_b30(rb30), .apparent_b30(ab30),
      .active_sign_total(sgt), .active_sign_fund(sgf),
      .fund_var_sign(vs), .pulse_path_sum_sign(ps), .pulse_raw_n(raw_n),
      .half_cycle_tick(stb[0]), .dsp_cycle_done(stb[1]),
      .harmonic_setup(stb[2]), .harmonic_update(stb[3]),
      .energy_pulse_out_1(pout[0]), .energy_pulse_out_2(pout[1]),
      .energy_pulse_out_3(pout[2]), .interrupt_out_1_n(irq),
      .pulse_out1_power_select(s1), .pulse_out2_power_select(s2),
      .pulse_out3_power_select(s3), .harmonic_update_rate(rate));

   meie_host_irq host_u (.clk(clk), .nrst(nrst), .irq_n(irq),
                         .irq_count(irq_count));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Single word transfer, entered just after a rising edge
   task bus(input logic w, input logic [15:0] idx,
            input logic [31:0] wd);
      htrans <= 2'h2;
      haddr  <= {14'h0000, idx, 2'h0};
      hwrite <= w;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (!hreadyout) @(posedge clk);
      rd = hrdata;
   endtask

   task waitchk(input int n, input logic e);
      repeat (n) @(posedge clk);
      chk({31'h0, irq}, {31'h0, e});
      if (!e) nirq++;
   endtask

   task strobe(input int i);
      stb[i] <= 1'b1;
      @(posedge clk);
      stb <= 4'h0;
      @(posedge clk);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task t_regs;
      bus(1'b0, meie_pkg::MASK_IDX, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);                      // OKAY response
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, meie_pkg::MASK_IDX, 32'hFFFF_FFFF);
      bus(1'b0, meie_pkg::MASK_IDX, 32'h0);
      chk(rd, 32'h000F_FFFB);
      bus(1'b1, 16'h0123, 32'hFFFF_FFFF);
      bus(1'b0, 16'h0123, 32'h0);
      chk(rd, 32'h0);
      waitchk(1, 1'b1);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h0);
      $display("done: register access");
   endtask

   task ev(input int b);
      case (b)
         0: tb30[0] <= ~tb30[0];
         1: fb30[1] <= ~fb30[1];
         3: rb30[2] <= ~rb30[2];
         4: ab30[0] <= ~ab30[0];
         6, 7, 8: sgt[b-6] <= ~sgt[b-6];
         9: ps[0] <= ~ps[0];
         13: ps[1] <= ~ps[1];
         18: ps[2] <= ~ps[2];
         10, 11, 12: vs[b-10] <= ~vs[b-10];
         14, 15, 16: raw_n[b-14] <= 1'b0;
         default: stb[1] <= 1'b1;
      endcase
      @(posedge clk);
      stb <= 4'h0;
      @(posedge clk);
      chk({29'h0, pout}, 32'h7);
      raw_n <= 3'h7;
      waitchk(3, 1'b1);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h1 << b);
      waitchk(2, 1'b0);
      bus(1'b1, meie_pkg::STAT_IDX, 32'h1 << b);
      waitchk(2, 1'b1);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h0);
   endtask

   task t_events;
      bus(1'b1, meie_pkg::CFM_IDX, 32'h0000_0FD5);
      @(posedge clk);
      chk({23'h0, s3, s2, s1}, 32'h1D5);
      for (int b = 0; b < 19; b++) begin
         if (b != 2 && b != 5) ev(b);
      end
      $display("done: event sources");
   endtask

   task t_line;
      bus(1'b1, meie_pkg::LCYC_IDX, 32'h0001_0003);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h1 << 5);
      strobe(0);
      strobe(0);
      waitchk(2, 1'b1);
      strobe(0);
      waitchk(3, 1'b0);
      bus(1'b1, meie_pkg::STAT_IDX, 32'h1 << 5);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h0);
      $display("done: line cycle");
   endtask

   task t_sign;
      bus(1'b1, meie_pkg::ACCM_IDX, 32'h40);
      repeat (3) @(posedge clk);
      bus(1'b1, meie_pkg::STAT_IDX, 32'h000F_FFFF);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h1 << 6);
      sgt[0] <= ~sgt[0];
      waitchk(4, 1'b1);
      sgf[0] <= ~sgf[0];
      waitchk(4, 1'b0);
      bus(1'b1, meie_pkg::STAT_IDX, 32'h1 << 6);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h0);
      $display("done: sign source select");
   endtask

   task t_harm;
      bus(1'b1, meie_pkg::HCFG_IDX, 32'hA1);
      @(posedge clk);
      chk({29'h0, rate}, 32'h5);
      bus(1'b1, meie_pkg::MASK_IDX, 32'h1 << 19);
      strobe(3);
      waitchk(3, 1'b1);
      strobe(2);
      strobe(3);
      waitchk(3, 1'b0);
      bus(1'b1, meie_pkg::STAT_IDX, 32'h1 << 19);
      bus(1'b1, meie_pkg::HCFG_IDX, 32'h48);
      strobe(2);
      strobe(3);
      waitchk(3, 1'b1);
      repeat (8) @(posedge clk);
      strobe(3);
      waitchk(3, 1'b0);
      bus(1'b1, meie_pkg::STAT_IDX, 32'h1 << 19);
      waitchk(2, 1'b1);
      $display("done: harmonic ready");
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         end_of_test();
      end
   end

   initial begin
      nrst = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
      hwdata = 32'h0; tb30 = 3'h0; fb30 = 3'h0; rb30 = 3'h0;
      ab30 = 3'h0; sgt = 3'h0; sgf = 3'h0; vs = 3'h0; ps = 3'h0;
      raw_n = 3'h7; stb = 4'h0; errors = 0; tests_run = 0; nirq = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_events();
      t_line();
      t_sign();
      t_harm();
      chk({16'h0, irq_count}, nirq);
      end_of_test();
   end
endmodule
